//--- include/ctu_pkg.sv
// Constants and carrier types of the charge time edge unit
`default_nettype none
package ctu_pkg;
  // Current control register fields
  localparam int CUR_RANGE_LSB = 0;
  localparam int CUR_TRIM_LSB = 2;
  // Low control register fields
  localparam int LO_STAT_A = 0;
  localparam int LO_STAT_B = 1;
  localparam int LO_SRC_A_LSB = 2;
  localparam int LO_POL_A = 4;
  localparam int LO_SRC_B_LSB = 5;
  localparam int LO_POL_B = 7;
  // High control register fields
  localparam int HI_TRIG_EN = 0;
  localparam int HI_DISCHARGE = 1;
  localparam int HI_ORDER_EN = 2;
  localparam int HI_EDGE_EN = 3;
  localparam int HI_DELAY_MODE = 4;
  localparam int HI_UNIT_EN = 7;
  // Peripheral flag and enable bit position
  localparam int PERIPH_BIT = 3;
  // Reset values
  localparam logic [7:0] CUR_CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_LOW_RST = 8'h00;
  localparam logic [7:0] CTRL_HIGH_RST = 8'h00;
  // ADC trigger pulse length in cycles
  localparam int ADC_PULSE_CYC = 1;

  typedef struct packed {
    logic [7:0] wdata;
    logic wrCur;
    logic wrLow;
    logic wrHigh;
  } ctu_wr_t;

  typedef struct packed {
    logic [7:0] curCtrl;
    logic [7:0] ctrlLow;
    logic [7:0] ctrlHigh;
  } ctu_regs_t;

  typedef struct packed {
    logic [3:0] srcA;
    logic [3:0] srcB;
  } ctu_src_t;
endpackage
`default_nettype wire

//--- rtl/ctu_edge_det.sv
// Polarity-selectable edge detector with source mux
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_det (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstN,
  // Sources and selection
  input wire logic [3:0] src,
  input wire logic [1:0] sel,
  input wire logic risingPol,
  input wire logic enable,
  // Detected edge
  output logic hit
);
  typedef struct packed {
    logic prev;
  } ctu_ed_state_t;

  ctu_ed_state_t st_r;
  ctu_ed_state_t st_nxt;
  logic cur;

  always_comb begin
    cur = src[sel];
    st_nxt.prev = cur;
    hit = 1'b0;
    if (enable) begin
      hit = risingPol ? (cur & ~st_r.prev) : (~cur & st_r.prev);
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ctu_pulse_end.sv
// Comparator-terminated delay pulse latch
`timescale 1ns/1ps
`default_nettype none
module ctu_pulse_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstN,
  // Control
  input wire logic active,
  input wire logic cmpOut,
  // Result
  output logic stopReq
);
  typedef struct packed {
    logic stop;
  } ctu_pe_state_t;

  ctu_pe_state_t st_r;
  ctu_pe_state_t st_nxt;

  always_comb begin
    st_nxt.stop = active & cmpOut;
    stopReq = st_r.stop;
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ctu_charge_time_unit.sv
// Control logic of the charge time edge unit
// Contract
// - Flag set on current source on-to-off
// - Interrupt request only when enable set
// - Range bits 1:0, trim bits 7:2
// - Edge source selects at 3:2, 6:5
// - Polarity bits 7 and 4, default falling
// - Ordering: edge B only after edge A
// - Edge status flags in bits 1:0
// - Mode bit: measure or delay generation
// - Trigger ADC after second edge if enabled, in measure mode only
// - Discharge bit grounds current source output; sourceDischarge asserts only while unit enable bit 7 is set
// - Unit runs only while enable set
// - Edge inputs pass only while enabled
// - Software status A write starts source
// - Capture/compare triggers usable as sources
// - Delay mode ends pulse on comparator 2
`timescale 1ns/1ps
`default_nettype none
module ctu_charge_time_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register writes from software
  input wire ctu_pkg::ctu_wr_t wr,
  input wire logic periphIntEn,
  input wire logic flagClear,
  // Edge sources: pins and capture/compare triggers
  input wire ctu_pkg::ctu_src_t edgeSrc,
  // Comparator 2 output
  input wire logic cmp2Out,
  // Register readback
  output ctu_pkg::ctu_regs_t regs,
  output logic periphFlag,
  // Analog controls
  output logic [1:0] currentRangeSel,
  output logic [5:0] currentTrim,
  output logic sourceOn,
  output logic sourceDischarge,
  output logic delayPulseOut,
  // Events
  output logic adcTrigger,
  output logic irqReq
);
  typedef struct packed {
    logic [1:0] rstSync;
    ctu_pkg::ctu_regs_t regs;
    logic flag;
    logic srcOnPrev;
    logic srcOut;
    logic discharge;
    logic pulseOut;
    logic adcTrig;
    logic irq;
  } ctu_state_t;

  ctu_state_t st_r;
  ctu_state_t st_nxt;
  logic rstN;
  logic hitA;
  logic hitB;
  logic unitEn;
  logic edgesEn;
  logic delayMode;
  logic srcOnNow;
  logic stopReq;
  logic [7:0] lowNext;

  assign rstN = st_r.rstSync[1];
  assign unitEn = st_r.regs.ctrlHigh[ctu_pkg::HI_UNIT_EN];
  assign edgesEn = unitEn
    & st_r.regs.ctrlHigh[ctu_pkg::HI_EDGE_EN];
  assign delayMode = st_r.regs.ctrlHigh[ctu_pkg::HI_DELAY_MODE];

  // Edge A: pins and capture/compare triggers share the mux
  ctu_edge_det edgeA (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .src(edgeSrc.srcA),
    .sel(st_r.regs.ctrlLow[ctu_pkg::LO_SRC_A_LSB +: 2]),
    .risingPol(st_r.regs.ctrlLow[ctu_pkg::LO_POL_A]),
    .enable(edgesEn),
    .hit(hitA)
  );

  ctu_edge_det edgeB (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .src(edgeSrc.srcB),
    .sel(st_r.regs.ctrlLow[ctu_pkg::LO_SRC_B_LSB +: 2]),
    .risingPol(st_r.regs.ctrlLow[ctu_pkg::LO_POL_B]),
    .enable(edgesEn),
    .hit(hitB)
  );

  ctu_pulse_end pulseEnd (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .active(unitEn & delayMode & srcOnNow),
    .cmpOut(cmp2Out),
    .stopReq(stopReq)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rstSync = {st_r.rstSync[0], 1'b1};
    // Software writes
    if (wr.wrCur) begin
      st_nxt.regs.curCtrl = wr.wdata;
    end
    if (wr.wrHigh) begin
      st_nxt.regs.ctrlHigh = wr.wdata;
    end
    lowNext = wr.wrLow ? wr.wdata : st_r.regs.ctrlLow;
    // Hardware edges set status; set wins over software write
    if (hitA) begin
      lowNext[ctu_pkg::LO_STAT_A] = 1'b1;
    end
    if (hitB && (!st_r.regs.ctrlHigh[ctu_pkg::HI_ORDER_EN]
        || st_r.regs.ctrlLow[ctu_pkg::LO_STAT_A])) begin
      lowNext[ctu_pkg::LO_STAT_B] = 1'b1;
    end
    // Comparator 2 ends the delay pulse by closing the second edge
    if (stopReq) begin
      lowNext[ctu_pkg::LO_STAT_B] = lowNext[ctu_pkg::LO_STAT_A];
    end
    st_nxt.regs.ctrlLow = lowNext;
    srcOnNow = unitEn
      & (st_r.regs.ctrlLow[ctu_pkg::LO_STAT_A]
      ^ st_r.regs.ctrlLow[ctu_pkg::LO_STAT_B]);
    st_nxt.srcOnPrev = srcOnNow;
    // Analog controls leave through flip-flops
    st_nxt.srcOut = srcOnNow
      & ~st_nxt.regs.ctrlHigh[ctu_pkg::HI_DISCHARGE];
    st_nxt.discharge = st_nxt.regs.ctrlHigh[ctu_pkg::HI_UNIT_EN]
      & st_nxt.regs.ctrlHigh[ctu_pkg::HI_DISCHARGE];
    st_nxt.pulseOut = srcOnNow
      & st_nxt.regs.ctrlHigh[ctu_pkg::HI_DELAY_MODE];
    // Flag: hardware set wins over software clear
    if (flagClear) begin
      st_nxt.flag = 1'b0;
    end
    if (st_r.srcOnPrev && !srcOnNow) begin
      st_nxt.flag = 1'b1;
    end
    st_nxt.irq = st_nxt.flag & periphIntEn;
    // ADC trigger on a fresh second edge
    st_nxt.adcTrig = unitEn & ~delayMode
      & st_r.regs.ctrlHigh[ctu_pkg::HI_TRIG_EN]
      & ~st_r.regs.ctrlLow[ctu_pkg::LO_STAT_B]
      & lowNext[ctu_pkg::LO_STAT_B];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r.rstSync <= 2'h0;
      st_r.regs.curCtrl <= ctu_pkg::CUR_CTRL_RST;
      st_r.regs.ctrlLow <= ctu_pkg::CTRL_LOW_RST;
      st_r.regs.ctrlHigh <= ctu_pkg::CTRL_HIGH_RST;
      st_r.flag <= 1'b0;
      st_r.srcOnPrev <= 1'b0;
      st_r.srcOut <= 1'b0;
      st_r.discharge <= 1'b0;
      st_r.pulseOut <= 1'b0;
      st_r.adcTrig <= 1'b0;
      st_r.irq <= 1'b0;
    end else if (!st_r.rstSync[1]) begin
      st_r.rstSync <= st_nxt.rstSync;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regs = st_r.regs;
  assign periphFlag = st_r.flag;
  assign currentRangeSel = st_r.regs.curCtrl[ctu_pkg::CUR_RANGE_LSB +: 2];
  assign currentTrim = st_r.regs.curCtrl[ctu_pkg::CUR_TRIM_LSB +: 6];
  assign sourceOn = st_r.srcOut;
  assign sourceDischarge = st_r.discharge;
  assign delayPulseOut = st_r.pulseOut;
  assign adcTrigger = st_r.adcTrig;
  assign irqReq = st_r.irq;
endmodule
`default_nettype wire

//--- tb/ctu_checker.sv
// Port assertions of the charge time unit
`timescale 1ns/1ps
`default_nettype none
module ctu_checker (
  // Clock, reset and inputs
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ctu_pkg::ctu_wr_t wr,
  input wire logic periphIntEn,
  // Outputs
  input wire ctu_pkg::ctu_regs_t regs,
  input wire logic periphFlag,
  input wire logic [1:0] currentRangeSel,
  input wire logic [5:0] currentTrim,
  input wire logic sourceOn,
  input wire logic sourceDischarge,
  input wire logic adcTrigger,
  input wire logic irqReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  flag_set_a: assert property (
    $fell(sourceOn) && !sourceDischarge |-> ##[0:2] periphFlag)
    else $error("flag not set");
  irq_mask_a: assert property (
    !periphIntEn [*2] |-> !irqReq) else $error("irq while masked");
  field_map_a: assert property (
    $stable(regs.curCtrl) |-> {currentTrim, currentRangeSel} == regs.curCtrl)
    else $error("range or trim wrong");
  discharge_level_a: assert property (
    $stable(regs.ctrlHigh) |->
    sourceDischarge == (regs.ctrlHigh[7] && regs.ctrlHigh[1]))
    else $error("discharge wrong");
  unit_off_a: assert property (
    !regs.ctrlHigh[7] [*2] |-> !sourceOn && !adcTrigger)
    else $error("active while off");
  order_gate_a: assert property (
    $rose(regs.ctrlLow[1]) && $past(regs.ctrlHigh[2]) && !$past(wr.wrLow)
    |-> $past(regs.ctrlLow[0])) else $error("edge B out of order");
  trig_pulse_a: assert property (
    adcTrigger |-> ($past(regs.ctrlHigh[0]) && regs.ctrlLow[1]) ##1
    !adcTrigger) else $error("bad trigger");
  source_on_a: assert property (
    sourceOn |-> $past(regs.ctrlLow[0] ^ regs.ctrlLow[1]))
    else $error("source on without status");
endmodule
`default_nettype wire

//--- tb/ctu_edge_model.sv
// Edge source lines and comparator 2 outside the unit
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_model (
  // Clock and requests
  input wire logic clk_sys,
  input wire logic [3:0] pulseA,
  input wire logic [3:0] pulseB,
  input wire logic srcOn,
  // Far side outputs
  output ctu_pkg::ctu_src_t edgeSrc,
  output logic cmp2Out
);
  logic [15:0] d = '0;
  int chg = 0;
  // Lines idle high, low two cycles per request; 0..1 pins, 2..3 triggers
  always @(posedge clk_sys) d <= {d[7:0], pulseB, pulseA};
  assign edgeSrc = '{~(d[3:0] | d[11:8]), ~(d[7:4] | d[15:12])};
  always @(posedge clk_sys) chg <= srcOn ? chg + 1 : 0;
  assign cmp2Out = chg >= 4;
endmodule
`default_nettype wire

//--- tb/ctu_charge_time_unit_bench.sv
// Self-checking bench of the charge time unit
`timescale 1ns/1ps
`default_nettype none
module ctu_charge_time_unit_bench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic periphIntEn = 1'b0;
  logic flagClear = 1'b0;
  logic [3:0] pa = 4'h0;
  logic [3:0] pb = 4'h0;
  logic cmp2Out, periphFlag, sourceOn, sourceDischarge;
  logic delayPulseOut, adcTrigger, irqReq;
  logic [1:0] currentRangeSel;
  logic [5:0] currentTrim;
  ctu_pkg::ctu_wr_t wr = '0;
  ctu_pkg::ctu_src_t edgeSrc;
  ctu_pkg::ctu_regs_t regs;
  int errors = 0;
  int tests_run = 0;
  int trigs = 0;
  ctu_charge_time_unit dut_u (.clk_sys, .arst_n, .wr, .periphIntEn,
    .flagClear, .edgeSrc, .cmp2Out, .regs, .periphFlag, .currentRangeSel,
    .currentTrim, .sourceOn, .sourceDischarge, .delayPulseOut,
    .adcTrigger, .irqReq);
  ctu_edge_model em_u (.clk_sys, .pulseA(pa), .pulseB(pb),
    .srcOn(sourceOn), .edgeSrc, .cmp2Out);
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (adcTrigger === 1'b1) trigs <= trigs + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic w(input int k, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= '{d, k == 0, k == 1, k == 2};
    @(posedge clk_sys);
    wr <= '0;
  endtask
  task automatic p(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk_sys);
    pa <= a;
    pb <= b;
    @(posedge clk_sys);
    pa <= 4'h0;
    pb <= 4'h0;
    tick(8);
  endtask
  task automatic fclr;
    @(posedge clk_sys);
    flagClear <= 1'b1;
    @(posedge clk_sys);
    flagClear <= 1'b0;
  endtask
  task automatic c(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task close_out;
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_rst;
    c("regs", 8'h00, regs.curCtrl | regs.ctrlLow | regs.ctrlHigh);
    w(0, 8'hA5);
    tick(2);
    c("range", 8'h01, currentRangeSel);
    c("trim", 8'h29, currentTrim);
  endtask
  task automatic t_meas;
    w(2, 8'h00);
    w(1, 8'h00);
    w(2, 8'h08);
    w(2, 8'h89);
    w(1, 8'h44);
    periphIntEn <= 1'b1;
    p(4'h2, 4'h0);
    c("on", 8'h01, sourceOn);
    p(4'h0, 4'h2);
    c("stB", 8'h00, regs.ctrlLow[1]);
    p(4'h0, 4'h4);
    c("low", 8'h47, regs.ctrlLow);
    c("off", 8'h00, sourceOn);
    c("trig", 8'h01, trigs[7:0]);
    c("irq", 8'h03, {periphFlag, irqReq});
    fclr;
    periphIntEn <= 1'b0;
    tick(3);
    c("clr", 8'h00, {periphFlag, irqReq});
  endtask
  task automatic t_ord;
    w(2, 8'h80);
    w(1, 8'hD4);
    p(4'h2, 4'h0);
    c("blk", 8'h00, regs.ctrlLow[0]);
    w(2, 8'h8C);
    p(4'h0, 4'h4);
    c("ord", 8'h00, regs.ctrlLow[1]);
    p(4'h2, 4'h0);
    p(4'h0, 4'h4);
    c("rise", 8'hD7, regs.ctrlLow);
  endtask
  task automatic t_soft;
    w(2, 8'h88);
    w(1, 8'h01);
    tick(3);
    c("swA", 8'h01, sourceOn);
    w(2, 8'h8A);
    tick(3);
    c("dis", 8'h02, {sourceDischarge, sourceOn});
  endtask
  task automatic t_dly;
    w(2, 8'h00);
    w(1, 8'h00);
    fclr;
    tick(2);
    c("pre", 8'h00, periphFlag);
    w(2, 8'h99);
    w(1, 8'h01);
    tick(3);
    c("pulse", 8'h01, delayPulseOut);
    tick(10);
    c("end", 8'h02, {regs.ctrlLow[1], delayPulseOut});
    c("notrig", 8'h01, trigs[7:0]);
    c("msk", 8'h02, {periphFlag, irqReq});
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(3);
    t_rst;
    t_meas;
    t_ord;
    t_soft;
    t_dly;
    close_out;
  end
  initial begin
    #200us;
    errors++;
    close_out;
  end
endmodule
bind ctu_charge_time_unit ctu_checker chk_u (.clk_sys, .arst_n, .wr,
  .periphIntEn, .regs, .periphFlag, .currentRangeSel, .currentTrim,
  .sourceOn, .sourceDischarge, .adcTrigger, .irqReq);
`default_nettype wire
